// ===== design/bbx_pkg.sv
// package: opcode fields, register map and reset values for the byte/bit execute block
package bbx_pkg;

	// instruction field positions
	localparam int OPC_HI      = 13;
	localparam int OPC_LO      = 8;
	localparam int GRP_HI      = 13;
	localparam int GRP_LO      = 12;
	localparam int SUB_HI      = 11;
	localparam int SUB_LO      = 10;
	localparam int DEST_BIT    = 7;
	localparam int BIDX_HI     = 9;
	localparam int BIDX_LO     = 7;
	localparam int FADDR_HI    = 6;
	localparam int FADDR_LO    = 0;

	// opcode codes
	localparam logic [5:0] OPC_ADD_ACC_FILE = 6'h07;
	localparam logic [5:0] OPC_AND_ACC_FILE = 6'h05;
	localparam logic [1:0] GRP_BIT_OPS      = 2'h1;
	localparam logic [1:0] SUB_BIT_CLEAR    = 2'h0;
	localparam logic [1:0] SUB_BIT_SET      = 2'h1;
	localparam logic [1:0] SUB_SKIP_ZERO    = 2'h2;
	localparam logic [1:0] SUB_SKIP_ONE     = 2'h3;
	localparam logic       DEST_ACC         = 1'h0;

	// register map, byte addresses
	localparam logic [4:0] REG_ACC_OFS      = 5'h00;
	localparam logic [4:0] REG_STATUS_OFS   = 5'h04;
	localparam logic [4:0] REG_CTRL_OFS     = 5'h08;
	localparam logic [4:0] REG_EXEC_CNT_OFS = 5'h0c;
	localparam logic [4:0] REG_SKIP_CNT_OFS = 5'h10;
	localparam logic [4:0] REG_LAST_OFS     = 5'h14;

	// status layout
	localparam int STS_CARRY  = 0;
	localparam int STS_NIBBLE = 1;
	localparam int STS_ZERO   = 2;
	localparam int CTRL_RUN   = 0;

	// reset values
	localparam logic [7:0]  ACC_RST    = 8'h00;
	localparam logic [2:0]  STATUS_RST = 3'h0;
	localparam logic        RUN_RST    = 1'h1;
	localparam logic [13:0] LAST_RST   = 14'h0000;

	typedef enum logic [2:0]
	{
		BBX_OP_ADD   = 3'h0,
		BBX_OP_AND   = 3'h1,
		BBX_OP_CLEAR = 3'h2,
		BBX_OP_SET   = 3'h3,
		BBX_OP_TEST  = 3'h4,
		BBX_OP_NONE  = 3'h5
	} bbx_op_e;

	typedef enum logic [1:0]
	{
		BBX_ST_EXEC = 2'b01,
		BBX_ST_SKIP = 2'b10
	} bbx_state_e;

endpackage : bbx_pkg

// ===== design/bbx_alu.sv
// arithmetic and bit manipulation datapath of the execute block
`timescale 1ns/1ps
module bbx_alu
	import bbx_pkg::*;
(
	input  wire logic [7:0] acc,
	input  wire logic [7:0] fval,
	input  wire logic [2:0] bit_idx,
	input  bbx_op_e         op,
	output logic      [7:0] result,
	output logic            carry,
	output logic            nibble_carry,
	output logic            zero,
	output logic            bit_val
);

	wire [8:0] sum_full   = {1'b0, acc} + {1'b0, fval};
	wire [4:0] sum_nibble = {1'b0, acc[3:0]} + {1'b0, fval[3:0]};
	wire [7:0] bit_mask   = 8'h01 << bit_idx;

	assign carry        = sum_full[8];
	assign nibble_carry = sum_nibble[4];
	assign bit_val      = fval[bit_idx];
	assign zero         = (result == 8'h00);

	always_comb
	begin
		case (op)
			BBX_OP_ADD:   result = sum_full[7:0];
			BBX_OP_AND:   result = acc & fval;
			BBX_OP_CLEAR: result = fval & ~bit_mask;
			BBX_OP_SET:   result = fval | bit_mask;
			default:      result = fval;
		endcase
	end

endmodule : bbx_alu

// ===== design/bbx_exec.sv
// byte add/and and bit clear/set/test-skip execute block with avalon register access
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module bbx_exec
	import bbx_pkg::*;
#(
	parameter int CNT_W = 16
)
(
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// avalon-mm slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// instruction stream
	input  wire logic [13:0] instr_word,
	input  wire logic        instr_valid,
	output logic             instr_ready,
	output logic             fetch_flush,
	// file register port
	output logic      [6:0]  file_raddr,
	input  wire logic [7:0]  file_rdata,
	input  wire logic [7:0]  file_pin_rdata,
	input  wire logic        file_is_io,
	output logic             file_wr_en,
	output logic      [6:0]  file_waddr,
	output logic      [7:0]  file_wdata,
	// core state
	output logic      [7:0]  acc_out,
	output logic             carry_flag,
	output logic             nibble_carry_flag,
	output logic             zero_flag
);

	bbx_state_e         state_r;
	bbx_state_e         state_nxt;
	logic [7:0]         acc_r;
	logic [7:0]         acc_nxt;
	logic [2:0]         status_r;
	logic [2:0]         status_nxt;
	logic               run_r;
	logic [CNT_W-1:0]   exec_cnt_r;
	logic [CNT_W-1:0]   skip_cnt_r;
	logic [13:0]        last_r;
	logic               ack_r;
	logic [31:0]        rdata_r;
	logic               wr_en_r;
	logic [6:0]         waddr_r;
	logic [7:0]         wdata_r;
	logic               wr_en_nxt;

	// decode
	wire [5:0] opc      = instr_word[OPC_HI:OPC_LO];
	wire [1:0] grp      = instr_word[GRP_HI:GRP_LO];
	wire [1:0] sub      = instr_word[SUB_HI:SUB_LO];
	wire       dest_sel = instr_word[DEST_BIT];
	wire [2:0] bit_idx  = instr_word[BIDX_HI:BIDX_LO];
	wire [6:0] faddr    = instr_word[FADDR_HI:FADDR_LO];

	wire is_add   = (opc == OPC_ADD_ACC_FILE);
	wire is_and   = (opc == OPC_AND_ACC_FILE);
	wire is_bit   = (grp == GRP_BIT_OPS);
	wire is_clear = is_bit && (sub == SUB_BIT_CLEAR);
	wire is_set   = is_bit && (sub == SUB_BIT_SET);
	wire is_szero = is_bit && (sub == SUB_SKIP_ZERO);
	wire is_sone  = is_bit && (sub == SUB_SKIP_ONE);

	wire take      = instr_valid && instr_ready;
	// the word after a taken skip is the prefetched one; it runs as no_operation
	wire discard   = take && (state_r == BBX_ST_SKIP);
	wire live      = take && (state_r == BBX_ST_EXEC);

	bbx_op_e alu_op;
	assign alu_op = is_add   ? BBX_OP_ADD :
	                is_and   ? BBX_OP_AND :
	                is_clear ? BBX_OP_CLEAR :
	                is_set   ? BBX_OP_SET :
	                (is_szero || is_sone) ? BBX_OP_TEST : BBX_OP_NONE;

	// io registers are read at the pins, not at the output latch
	wire [7:0] src_val = file_is_io ? file_pin_rdata : file_rdata;

	wire [7:0] alu_result;
	wire       alu_carry;
	wire       alu_nibble;
	wire       alu_zero;
	wire       alu_bit;

	bbx_alu u_alu
	(
		.acc          (acc_r),
		.fval         (src_val),
		.bit_idx      (bit_idx),
		.op           (alu_op),
		.result       (alu_result),
		.carry        (alu_carry),
		.nibble_carry (alu_nibble),
		.zero         (alu_zero),
		.bit_val      (alu_bit)
	);

	wire skip_hit = live && ((is_szero && !alu_bit) ||
	                         (is_sone && alu_bit));
	wire byte_op  = live && (is_add || is_and);
	wire to_acc   = byte_op && (dest_sel == DEST_ACC);
	wire to_file  = (byte_op && (dest_sel != DEST_ACC)) ||
	                (live && (is_clear || is_set));

	assign instr_ready = run_r;
	assign fetch_flush = skip_hit;
	assign file_raddr  = faddr;

	// bus decode
	wire bus_req   = avs_read || avs_write;
	wire bus_wr    = avs_write && ack_r && avs_byteenable[0];
	wire hit_acc   = (avs_address == REG_ACC_OFS);
	wire hit_sts   = (avs_address == REG_STATUS_OFS);
	wire hit_ctrl  = (avs_address == REG_CTRL_OFS);
	wire hit_exec  = (avs_address == REG_EXEC_CNT_OFS);
	wire hit_skip  = (avs_address == REG_SKIP_CNT_OFS);
	wire hit_last  = (avs_address == REG_LAST_OFS);

	wire [31:0] rd_mux =
		hit_acc  ? {24'h000000, acc_r} :
		hit_sts  ? {29'h00000000, status_r} :
		hit_ctrl ? {31'h00000000, run_r} :
		hit_exec ? {{(32-CNT_W){1'b0}}, exec_cnt_r} :
		hit_skip ? {{(32-CNT_W){1'b0}}, skip_cnt_r} :
		hit_last ? {18'h00000, last_r} : 32'h00000000;

	// one wait state: the bus sees waitrequest low on the second cycle
	assign avs_waitrequest = bus_req && !ack_r;
	assign avs_readdata    = rdata_r;

	// accumulator: a retiring instruction wins over a bus write in the same cycle
	always_comb
	begin
		acc_nxt = acc_r;
		if (to_acc)
		begin
			acc_nxt = alu_result;
		end
		else if (bus_wr && hit_acc)
		begin
			acc_nxt = avs_writedata[7:0];
		end
	end

	// flags: add touches all three, and touches zero only, bit ops touch none
	always_comb
	begin
		status_nxt = status_r;
		if (byte_op && is_add)
		begin
			status_nxt[STS_CARRY]  = alu_carry;
			status_nxt[STS_NIBBLE] = alu_nibble;
			status_nxt[STS_ZERO]   = alu_zero;
		end
		else if (byte_op && is_and)
		begin
			status_nxt[STS_ZERO] = alu_zero;
		end
		else if (bus_wr && hit_sts)
		begin
			status_nxt = avs_writedata[2:0];
		end
	end

	// skip sequencing
	always_comb
	begin
		case (state_r)
			BBX_ST_EXEC:
			begin
				state_nxt = skip_hit ? BBX_ST_SKIP : BBX_ST_EXEC;
			end
			BBX_ST_SKIP:
			begin
				state_nxt = discard ? BBX_ST_EXEC : BBX_ST_SKIP;
			end
			default:
			begin
				state_nxt = BBX_ST_EXEC;
			end
		endcase
	end

	assign wr_en_nxt = to_file;

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			state_r  <= BBX_ST_EXEC;
			acc_r    <= ACC_RST;
			status_r <= STATUS_RST;
		end
		else
		begin
			state_r  <= state_nxt;
			acc_r    <= acc_nxt;
			status_r <= status_nxt;
		end
	end

	// file write-back, one cycle after the instruction is taken
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			wr_en_r <= 1'b0;
			waddr_r <= 7'h00;
			wdata_r <= 8'h00;
		end
		else
		begin
			wr_en_r <= wr_en_nxt;
			waddr_r <= faddr;
			wdata_r <= alu_result;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			run_r <= RUN_RST;
		end
		else if (bus_wr && hit_ctrl)
		begin
			run_r <= avs_writedata[CTRL_RUN];
		end
	end

	// counters wrap; discarded words count as executed no_operation
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			exec_cnt_r <= '0;
			skip_cnt_r <= '0;
			last_r     <= LAST_RST;
		end
		else
		begin
			if (take)
			begin
				exec_cnt_r <= exec_cnt_r + 1'b1;
			end
			if (skip_hit)
			begin
				skip_cnt_r <= skip_cnt_r + 1'b1;
			end
			if (live)
			begin
				last_r <= instr_word;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h00000000;
		end
		else
		begin
			ack_r <= bus_req && !ack_r;
			if (avs_read && !ack_r)
			begin
				rdata_r <= rd_mux;
			end
		end
	end

	assign file_wr_en        = wr_en_r;
	assign file_waddr        = waddr_r;
	assign file_wdata        = wdata_r;
	assign acc_out           = acc_r;
	assign carry_flag        = status_r[STS_CARRY];
	assign nibble_carry_flag = status_r[STS_NIBBLE];
	assign zero_flag         = status_r[STS_ZERO];

endmodule : bbx_exec

// ===== tb/bbx_exec_props.sv
// checker: execute-block properties seen at the top module ports
`timescale 1ns/1ps
module bbx_exec_props
	import bbx_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        resetn,
	input wire logic [13:0] instr_word,
	input wire logic        instr_valid,
	input wire logic        instr_ready,
	input wire logic        fetch_flush,
	input wire logic [7:0]  file_rdata,
	input wire logic [7:0]  file_pin_rdata,
	input wire logic        file_is_io,
	input wire logic        file_wr_en,
	input wire logic [6:0]  file_waddr,
	input wire logic [7:0]  file_wdata,
	input wire logic [7:0]  acc_out,
	input wire logic        carry_flag,
	input wire logic        nibble_carry_flag,
	input wire logic        zero_flag
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	logic       disc_r;
	wire        taken = instr_valid & instr_ready;
	wire        live  = taken & !disc_r;
	wire [7:0]  src   = file_is_io ? file_pin_rdata : file_rdata;
	wire [8:0]  sum   = {1'b0, acc_out} + {1'b0, src};
	wire [4:0]  nsum  = {1'b0, acc_out[3:0]} + {1'b0, src[3:0]};
	wire [7:0]  res   = sum[7:0];
	wire [7:0]  andv  = acc_out & src;
	wire [7:0]  msk   = 8'h01 << instr_word[BIDX_HI:BIDX_LO];
	wire [7:0]  clrv  = src & ~msk;
	wire [7:0]  setv  = src | msk;
	wire [6:0]  faddr = instr_word[FADDR_HI:FADDR_LO];
	wire [1:0]  sub   = instr_word[SUB_HI:SUB_LO];
	wire        bitv  = |(src & msk);
	wire [2:0]  flg   = {zero_flag, nibble_carry_flag, carry_flag};
	wire        isadd = live && instr_word[OPC_HI:OPC_LO] == OPC_ADD_ACC_FILE;
	wire        isand = live && instr_word[OPC_HI:OPC_LO] == OPC_AND_ACC_FILE;
	wire        isbit = live && instr_word[GRP_HI:GRP_LO] == GRP_BIT_OPS;
	wire        dst   = instr_word[DEST_BIT];

	// a discarded word must not count as live
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			disc_r <= 1'b0;
		else if (fetch_flush)
			disc_r <= 1'b1;
		else if (taken)
			disc_r <= 1'b0;
	end

	sequence s_skip_taken;
		fetch_flush ##1 !taken ##1 taken;
	endsequence

	chk_add_flags: assert property (isadd |=> carry_flag == $past(sum[8]) && nibble_carry_flag == $past(nsum[4])
		&& zero_flag == ($past(res) == 8'h00)) else $error("add flags wrong");
	chk_add_acc: assert property (isadd && !dst |=> acc_out == $past(res) && !file_wr_en)
		else $error("add to acc wrong");
	chk_add_file: assert property (isadd && dst |=> file_wr_en && file_wdata == $past(res)
		&& file_waddr == $past(faddr) && $stable(acc_out)) else $error("add to file wrong");
	chk_and_zero: assert property (isand |=> $stable(carry_flag) && $stable(nibble_carry_flag)
		&& zero_flag == ($past(andv) == 8'h00)) else $error("and flags wrong");
	chk_clear_bit: assert property (isbit && sub == SUB_BIT_CLEAR |=> file_wr_en && file_wdata == $past(clrv)
		&& $stable(flg)) else $error("bit clear wrong");
	chk_set_bit: assert property (isbit && sub == SUB_BIT_SET |=> file_wr_en && file_wdata == $past(setv)
		&& $stable(flg)) else $error("bit set wrong");
	chk_skip_when: assert property (isbit && sub[1] |-> fetch_flush == (sub[0] ? bitv : !bitv))
		else $error("skip decision wrong");
	chk_skip_discard: assert property (s_skip_taken |=> !file_wr_en && $stable(acc_out) && $stable(flg))
		else $error("word after skip not discarded");
endmodule : bbx_exec_props

bind bbx_exec bbx_exec_props i_bbx_exec_props (.core_clk(core_clk), .resetn(resetn), .instr_word(instr_word),
	.instr_valid(instr_valid), .instr_ready(instr_ready), .fetch_flush(fetch_flush), .file_rdata(file_rdata),
	.file_pin_rdata(file_pin_rdata), .file_is_io(file_is_io), .file_wr_en(file_wr_en), .file_waddr(file_waddr),
	.file_wdata(file_wdata), .acc_out(acc_out), .carry_flag(carry_flag), .nibble_carry_flag(nibble_carry_flag),
	.zero_flag(zero_flag));

// ===== tb/bbx_exec_tb.sv
// testbench: register bus and instruction stream tests of the execute block
`timescale 1ns/1ps
module bbx_exec_tb
	import bbx_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [13:0] instr_word = 14'h0;
	logic        instr_valid = 1'b0;
	logic [7:0]  file_rdata = 8'h00;
	logic [7:0]  file_pin_rdata = 8'h00;
	logic        file_is_io = 1'b0;
	wire  [31:0] avs_readdata;
	wire  [6:0]  file_raddr, file_waddr;
	wire  [7:0]  file_wdata, acc_out;
	wire         avs_waitrequest, instr_ready, fetch_flush, file_wr_en, carry_flag, nibble_carry_flag, zero_flag;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          ni = 0;
	int          nw = 0;
	logic        fl, we;
	logic [6:0]  wa, ra;
	logic [7:0]  wd, ac;
	logic [2:0]  fg;
	logic [31:0] q;

	bbx_exec i_bbx_exec (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .instr_word(instr_word),
		.instr_valid(instr_valid), .instr_ready(instr_ready), .fetch_flush(fetch_flush), .file_raddr(file_raddr),
		.file_rdata(file_rdata), .file_pin_rdata(file_pin_rdata), .file_is_io(file_is_io), .file_wr_en(file_wr_en),
		.file_waddr(file_waddr), .file_wdata(file_wdata), .acc_out(acc_out), .carry_flag(carry_flag),
		.nibble_carry_flag(nibble_carry_flag), .zero_flag(zero_flag));

	always #12.5 core_clk = ~core_clk;

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value %s: expected %h, seen %h", nm, e, g);
		end
	endtask : cmp

	// request stands until waitrequest is seen low at an edge; read data taken at that edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n = 0;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0)
		begin
			n_fail++;
			report_and_stop();
		end
		q = avs_readdata;
		nw = n;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// one idle edge so the next call does not drive the strobes twice in one step
		@(posedge core_clk);
	endtask : bus

	task automatic issue(input logic [13:0] w, input logic [7:0] f, input logic [7:0] p, input logic io);
		instr_word <= w;
		file_rdata <= f;
		file_pin_rdata <= p;
		file_is_io <= io;
		instr_valid <= 1'b1;
		#1 fl = fetch_flush;
		ra = file_raddr;
		@(posedge core_clk);
		instr_valid <= 1'b0;
		#1 {we, wa, wd, ac} = {file_wr_en, file_waddr, file_wdata, acc_out};
		fg = {zero_flag, nibble_carry_flag, carry_flag};
		ni++;
		@(posedge core_clk);
	endtask : issue

	initial
	begin
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		bus(1'b1, 5'h18, 32'hff);
		for (int i = 0; i < 7; i++)
		begin
			bus(1'b0, 5'(i * 4), 32'h0);
			cmp("reset reg", {31'h0, i == 2}, q);
		end
		cmp("wait edges", 32'h2, 32'(nw));
		avs_byteenable <= 4'h0;
		bus(1'b1, REG_ACC_OFS, 32'h55);
		avs_byteenable <= 4'hf;
		bus(1'b0, REG_ACC_OFS, 32'h0);
		cmp("masked write", 32'h0, q);
		bus(1'b1, REG_CTRL_OFS, 32'h0);
		cmp("ready off", 32'h0, 32'(instr_ready));
		issue({OPC_ADD_ACC_FILE, 1'b1, 7'h01}, 8'h01, 8'h00, 1'b0);
		cmp("stopped write", 32'h0, 32'(we));
		ni = 0;
		bus(1'b1, REG_CTRL_OFS, 32'h1);
		bus(1'b0, REG_EXEC_CNT_OFS, 32'h0);
		cmp("stopped count", 32'h0, q);
		$display("test registers done");
		bus(1'b1, REG_ACC_OFS, 32'h17);
		issue({OPC_ADD_ACC_FILE, 1'b0, 7'h05}, 8'hc2, 8'h00, 1'b0);
		cmp("read address", 32'h05, 32'(ra));
		cmp("add acc", 32'hd9, 32'(ac));
		cmp("add flags", 32'h0, 32'({fg, we}));
		bus(1'b1, REG_ACC_OFS, 32'hff);
		issue({OPC_ADD_ACC_FILE, 1'b1, 7'h7f}, 8'h01, 8'h00, 1'b0);
		cmp("add file", 32'({1'b1, 7'h7f, 8'h00, 8'hff, 3'h7}), 32'({we, wa, wd, ac, fg}));
		issue({OPC_ADD_ACC_FILE, 1'b0, 7'h02}, 8'h00, 8'h01, 1'b1);
		cmp("add io", 32'h0, 32'(ac));
		bus(1'b1, REG_ACC_OFS, 32'hf5);
		issue({OPC_AND_ACC_FILE, 1'b0, 7'h10}, 8'h5a, 8'h00, 1'b0);
		cmp("and acc", 32'h350, 32'({fg, ac}));
		issue({OPC_AND_ACC_FILE, 1'b1, 7'h11}, 8'h0a, 8'h00, 1'b0);
		cmp("and file", 32'({4'hf, 8'h00, 8'h50}), 32'({fg, we, wd, ac}));
		$display("test byte ops done");
		for (int i = 0; i < 8; i++)
		begin
			issue({GRP_BIT_OPS, SUB_BIT_CLEAR, 3'(i), 7'h20}, 8'hff, 8'h00, 1'b0);
			cmp("clear", 32'({4'hf, 7'h20, ~(8'h01 << i)}), 32'({fg, we, wa, wd}));
			issue({GRP_BIT_OPS, SUB_BIT_SET, 3'(i), 7'h21}, 8'hff, 8'h00, 1'b1);
			cmp("set", 32'({4'hf, 7'h21, 8'h01 << i}), 32'({fg, we, wa, wd}));
		end
		$display("test bit ops done");
		for (int k = 0; k < 4; k++)
		begin
			logic sk;
			sk = k[1] ? k[0] : !k[0];
			issue({GRP_BIT_OPS, k[1] ? SUB_SKIP_ONE : SUB_SKIP_ZERO, 3'h3, 7'h30}, {4'h0, k[0], 3'h0}, 8'h00, 1'b0);
			cmp("flush", 32'(sk), 32'(fl));
			issue({OPC_ADD_ACC_FILE, 1'b1, 7'h31}, 8'h01, 8'h00, 1'b0);
			cmp("after test", 32'(!sk), 32'(we));
		end
		bus(1'b0, REG_SKIP_CNT_OFS, 32'h0);
		cmp("skip count", 32'h2, q);
		bus(1'b0, REG_EXEC_CNT_OFS, 32'h0);
		cmp("word count", 32'(ni), q);
		bus(1'b0, REG_LAST_OFS, 32'h0);
		cmp("last word", 32'({GRP_BIT_OPS, SUB_SKIP_ONE, 3'h3, 7'h30}), q);
		$display("test skips done");
		report_and_stop();
	end
endmodule : bbx_exec_tb
